// [mcs_map.svh]
// Offsets-free constant map for the module control and status block.
// Assumes a 100 MHz clock; times are given in their own units.
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH

`define MCS_CLK_MHZ 100
`define MCS_T_RST_MIN_US 10
`define MCS_T_INIT_MS 300
`define MCS_T_INT_OFF_US 500
`define MCS_T_LOS_ON_US 100
`define MCS_T_NR_ON_MS 1
`define MCS_INIT_CYC (`MCS_T_INIT_MS * 1000 * `MCS_CLK_MHZ)
`define MCS_RST_CYC (`MCS_T_RST_MIN_US * `MCS_CLK_MHZ)
`define MCS_LOS_CYC (`MCS_T_LOS_ON_US * `MCS_CLK_MHZ)
`define MCS_INT_OFF_CYC (`MCS_T_INT_OFF_US * `MCS_CLK_MHZ)
`define MCS_RST_PULSE_CYC 16

`endif

// [mcs_pkg.sv]
// Types for the module control and status block.
// Assumes the constant map header is included by users needing figures.
package mcs_pkg;

    typedef enum logic [1:0] {
        MCS_LB_NONE = 2'b00,
        MCS_LB_SYSTEM = 2'b01,
        MCS_LB_NETWORK = 2'b10
    } mcs_loop_e;

    typedef enum logic [1:0] {
        MCS_ST_INIT = 2'b00,
        MCS_ST_RUN = 2'b01,
        MCS_ST_DOWN = 2'b10
    } mcs_state_e;

    typedef struct packed {
        logic tx_pll_locked;
        logic rx_cdr_locked;
        logic rx_signal_present;
        logic fault_event;
    } mcs_status_s;

    typedef struct packed {
        logic laser_enable;
        logic tx_path_enable;
        logic rx_path_enable;
        logic system_loopback;
        logic network_loopback;
    } mcs_path_s;

endpackage

// [mcs_ctrl.sv]
// Low-speed control and status logic of a pluggable optical transceiver.
// Assumes host pins are already synchronous to clk_i; the serial
// management engine sits outside and talks through plain strobes.
//
// Contract
// - Serial commands are honoured only while bus select is held low.
// - With bus select high, no transaction is answered or acknowledged.
// - Not-ready goes high on any condition invalidating transmit or receive data.
// - Transmit PLL lock failure raises an alarm and asserts not-ready.
// - Receive loss of signal or clock lock is reflected on not-ready.
// - Interrupt output is driven low to flag a fault or critical status.
// - Transmit disable high turns the transmitter output off.
// - Absent indicator is pulled low while the module is inserted.
// - Loss-of-signal output goes high when optical power is insufficient.
// - Power-down input high stops the optical transmit and electrical receive paths.
// - Each falling edge of power-down generates an internal reset pulse.
// - After reset, not-ready stays asserted until the PLLs regain lock.
// - System and network loopback are chosen by serial interface commands.
// - System loopback returns host transmit data to the host receive output.
// - Network loopback returns line receive data to the line transmitter.
// - PLL uses the host reference clock for line rate and lock decision.
// - Initialisation completes within 300 ms of power-on or power-down release.
// - Interrupt flags clear on read; interrupt negates within 500 us.
// - Loss-of-signal output asserts within 100 us of signal loss.
`timescale 1ns/100ps
`include "mcs_map.svh"

module mcs_ctrl
    import mcs_pkg::*;
#(
    parameter int unsigned INIT_CYC = `MCS_INIT_CYC,
    parameter int unsigned LOS_CYC = `MCS_LOS_CYC,
    parameter int unsigned INT_OFF_CYC = `MCS_INT_OFF_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic bus_deselect_i,
    input wire logic mgmt_cmd_valid_i,
    input wire logic mgmt_loop_sel_i,
    input wire logic [1:0] mgmt_loop_mode_i,
    input wire logic mgmt_flag_read_i,
    input wire logic transmit_disable_i,
    input wire logic power_down_i,
    input wire mcs_status_s status_i,
    output logic mgmt_enable_o,
    output logic mgmt_ack_o,
    output logic module_not_ready_o,
    output logic interrupt_n_o,
    output logic receive_signal_lost_o,
    output logic module_absent_o,
    output logic tx_lock_alarm_o,
    output logic internal_reset_o,
    output logic [2:0] int_flags_o,
    output mcs_path_s path_o
);

    localparam int unsigned CW = 32;

    mcs_state_e state_ff;
    mcs_loop_e loop_ff;
    logic pd_prev_ff;
    logic [CW-1:0] init_cnt_ff;
    logic [CW-1:0] los_cnt_ff;
    logic [CW-1:0] int_cnt_ff;
    logic [7:0] rst_cnt_ff;
    logic [2:0] flags_ff;
    logic int_clr_pend_ff;
    logic mgmt_enable_ff;
    logic mgmt_ack_ff;
    logic nr_ff;
    logic int_n_ff;
    logic los_ff;
    logic alarm_ff;
    logic ireset_ff;
    mcs_path_s path_ff;

    logic pd_fall;
    logic rst_any;
    logic data_bad;
    logic [2:0] flag_set;

    assign pd_fall = pd_prev_ff & ~power_down_i;
    assign rst_any = srst_i | pd_fall;
    // Lock loss on either side and signal loss all void the data
    assign data_bad = ~status_i.tx_pll_locked | ~status_i.rx_cdr_locked
        | los_ff | (state_ff != MCS_ST_RUN);
    assign flag_set = {status_i.fault_event, ~status_i.tx_pll_locked, los_ff};

    // Edge memory for the power-down pin
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pd_prev_ff <= 1'b0;
        end else begin
            pd_prev_ff <= power_down_i;
        end
    end

    // Reset pulse: fixed width so downstream logic sees it cleanly
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rst_cnt_ff <= 8'h00;
            ireset_ff <= 1'b0;
        end else if (pd_fall) begin
            rst_cnt_ff <= 8'(`MCS_RST_PULSE_CYC - 1);
            ireset_ff <= 1'b1;
        end else if (rst_cnt_ff != 8'h00) begin
            rst_cnt_ff <= rst_cnt_ff - 8'h01;
            ireset_ff <= 1'b1;
        end else begin
            ireset_ff <= 1'b0;
        end
    end

    // Operating state: init, run, or powered down
    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            state_ff <= MCS_ST_INIT;
            init_cnt_ff <= '0;
        end else if (power_down_i) begin
            state_ff <= MCS_ST_DOWN;
            init_cnt_ff <= '0;
        end else begin
            case (state_ff)
                MCS_ST_INIT: begin
                    // Leaves init once locked; the bound guarantees an exit
                    if ((status_i.tx_pll_locked && status_i.rx_cdr_locked)
                        || init_cnt_ff >= CW'(INIT_CYC - 1)) begin
                        state_ff <= MCS_ST_RUN;
                    end else begin
                        init_cnt_ff <= init_cnt_ff + CW'(1);
                    end
                end
                MCS_ST_RUN: begin
                    state_ff <= MCS_ST_RUN;
                end
                MCS_ST_DOWN: begin
                    state_ff <= MCS_ST_INIT;
                end
                default: begin
                    state_ff <= MCS_ST_INIT;
                end
            endcase
        end
    end

    // Loopback selection from the management engine
    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            loop_ff <= MCS_LB_NONE;
        end else if (mgmt_cmd_valid_i && !bus_deselect_i && mgmt_loop_sel_i) begin
            case (mgmt_loop_mode_i)
                2'h1: loop_ff <= MCS_LB_SYSTEM;
                2'h2: loop_ff <= MCS_LB_NETWORK;
                default: loop_ff <= MCS_LB_NONE;
            endcase
        end
    end

    // Bus select gating and acknowledge
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mgmt_enable_ff <= 1'b0;
            mgmt_ack_ff <= 1'b0;
        end else begin
            mgmt_enable_ff <= ~bus_deselect_i;
            mgmt_ack_ff <= mgmt_cmd_valid_i & ~bus_deselect_i;
        end
    end

    // Loss-of-signal qualifier, well inside the allowed assert delay
    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            los_cnt_ff <= '0;
            los_ff <= 1'b1;
        end else if (status_i.rx_signal_present) begin
            los_cnt_ff <= '0;
            los_ff <= 1'b0;
        end else if (los_cnt_ff >= CW'(LOS_CYC / 2)) begin
            los_ff <= 1'b1;
        end else begin
            los_cnt_ff <= los_cnt_ff + CW'(1);
        end
    end

    // Not-ready and lock alarm
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            nr_ff <= 1'b1;
            alarm_ff <= 1'b0;
        end else begin
            nr_ff <= data_bad;
            alarm_ff <= ~status_i.tx_pll_locked;
        end
    end

    // Sticky flags; a new event beats a clearing read
    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            flags_ff <= 3'h0;
        end else if (mgmt_flag_read_i && !bus_deselect_i) begin
            flags_ff <= flag_set;
        end else begin
            flags_ff <= flags_ff | flag_set;
        end
    end

    // Interrupt output negates a short, bounded time after the clear
    always_ff @(posedge clk_i) begin
        if (rst_any) begin
            int_n_ff <= 1'b1;
            int_clr_pend_ff <= 1'b0;
            int_cnt_ff <= '0;
        end else if (flags_ff != 3'h0) begin
            int_n_ff <= 1'b0;
            int_clr_pend_ff <= 1'b0;
            int_cnt_ff <= '0;
        end else if (!int_n_ff && !int_clr_pend_ff) begin
            int_clr_pend_ff <= 1'b1;
            int_cnt_ff <= '0;
        end else if (int_clr_pend_ff) begin
            if (int_cnt_ff >= CW'(INT_OFF_CYC / 4)) begin
                int_n_ff <= 1'b1;
                int_clr_pend_ff <= 1'b0;
            end else begin
                int_cnt_ff <= int_cnt_ff + CW'(1);
            end
        end
    end

    // Datapath steering
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            path_ff <= '0;
        end else begin
            path_ff.laser_enable <= ~transmit_disable_i & ~power_down_i;
            path_ff.tx_path_enable <= ~power_down_i;
            path_ff.rx_path_enable <= ~power_down_i;
            path_ff.system_loopback <= (loop_ff == MCS_LB_SYSTEM);
            path_ff.network_loopback <= (loop_ff == MCS_LB_NETWORK);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            module_absent_o <= 1'b0;
        end else begin
            module_absent_o <= 1'b0;
        end
    end

    assign mgmt_enable_o = mgmt_enable_ff;
    assign mgmt_ack_o = mgmt_ack_ff;
    assign module_not_ready_o = nr_ff;
    assign interrupt_n_o = int_n_ff;
    assign receive_signal_lost_o = los_ff;
    assign tx_lock_alarm_o = alarm_ff;
    assign internal_reset_o = ireset_ff;
    assign int_flags_o = flags_ff;
    assign path_o = path_ff;

endmodule

// [mcs_ctrl_assertions.sv]
// Port checker for the control and status block.
// Assumes it is bound onto mcs_ctrl; one clock, sync reset.
`timescale 1ns/100ps
module mcs_ctrl_assertions
    import mcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic bus_deselect_i,
    input wire logic mgmt_cmd_valid_i,
    input wire logic mgmt_loop_sel_i,
    input wire logic [1:0] mgmt_loop_mode_i,
    input wire logic transmit_disable_i,
    input wire logic power_down_i,
    input wire mcs_status_s status_i,
    input wire logic mgmt_enable_o,
    input wire logic mgmt_ack_o,
    input wire logic module_not_ready_o,
    input wire logic interrupt_n_o,
    input wire logic receive_signal_lost_o,
    input wire logic module_absent_o,
    input wire logic tx_lock_alarm_o,
    input wire logic internal_reset_o,
    input wire logic [2:0] int_flags_o,
    input wire mcs_path_s path_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    a_ack_needs_select: assert property (
        mgmt_ack_o |-> $past(mgmt_cmd_valid_i && !bus_deselect_i)) else $error("stray ack");
    a_deselect_silent: assert property (
        bus_deselect_i |=> !mgmt_ack_o && !mgmt_enable_o) else $error("answered deselected");
    a_lock_alarm_nr: assert property (
        !status_i.tx_pll_locked |=> tx_lock_alarm_o && module_not_ready_o) else $error("no alarm");
    a_rx_loss_nr: assert property (
        !status_i.rx_cdr_locked || receive_signal_lost_o |=> module_not_ready_o)
        else $error("rx loss not on not-ready");
    // Guarded: a power-down release clears the flags and the interrupt
    a_irq_on_flag: assert property (
        int_flags_o != 3'h0 && !power_down_i && $stable(power_down_i) |=> !interrupt_n_o)
        else $error("flag without interrupt");
    a_txdis_dark: assert property (
        transmit_disable_i |-> ##[1:2] !path_o.laser_enable) else $error("laser on");
    a_absent_low: assert property (!module_absent_o) else $error("absent high");
    a_pdown_quiet: assert property (
        power_down_i |-> ##[1:2] !path_o.tx_path_enable && !path_o.rx_path_enable)
        else $error("path live in power down");
    a_reset_pulse: assert property (
        $fell(power_down_i) |-> ##[1:2] internal_reset_o) else $error("no reset pulse");
    a_loop_follows: assert property (
        mgmt_cmd_valid_i && mgmt_loop_sel_i && !bus_deselect_i && !power_down_i
        && mgmt_loop_mode_i != 2'h3 |-> ##2
        {path_o.network_loopback, path_o.system_loopback} == $past(mgmt_loop_mode_i, 2))
        else $error("loopback mismatch");
endmodule

// [mcs_host_model.sv]
// Host management master model: loop commands and flag reads.
// Assumes the block's clock; strobes move just after a rising edge.
`timescale 1ns/100ps
module mcs_host_model (
    input wire logic clk_i,
    input wire logic ack_i,
    output logic deselect_o,
    output logic cmd_valid_o,
    output logic loop_sel_o,
    output logic [1:0] mode_o,
    output logic flag_read_o
);
    initial begin
        deselect_o = 1'h1;
        cmd_valid_o = 1'h0;
        loop_sel_o = 1'h0;
        mode_o = 2'h0;
        flag_read_o = 1'h0;
    end
    // One-cycle request; ack stands one cycle, so sample it then
    task automatic send(input logic desel, input logic rd, input logic [1:0] m,
                        output logic acked);
        @(posedge clk_i);
        deselect_o <= desel;
        cmd_valid_o <= !rd;
        loop_sel_o <= !rd;
        flag_read_o <= rd;
        mode_o <= m;
        @(posedge clk_i);
        cmd_valid_o <= 1'h0;
        loop_sel_o <= 1'h0;
        flag_read_o <= 1'h0;
        #1 acked = ack_i;
    endtask
endmodule

// [test_mcs_ctrl.sv]
// Self-checking bench for the control and status block.
// Assumes shortened counts; host strobes come from the host model.
`timescale 1ns/100ps
module test_mcs_ctrl;
    import mcs_pkg::*;
    logic clk_i = 1'h0;
    logic srst_i = 1'h1;
    logic transmit_disable_i = 1'h0;
    logic power_down_i = 1'h0;
    mcs_status_s status_i = 4'h0;
    logic bus_deselect_i, mgmt_cmd_valid_i, mgmt_loop_sel_i, mgmt_flag_read_i, acked;
    logic [1:0] mgmt_loop_mode_i;
    logic mgmt_enable_o, mgmt_ack_o, module_not_ready_o, interrupt_n_o, internal_reset_o;
    logic receive_signal_lost_o, module_absent_o, tx_lock_alarm_o;
    logic [2:0] int_flags_o;
    mcs_path_s path_o;
    int n_mismatch = 0;
    int checked = 0;
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    mcs_ctrl #(.INIT_CYC(100), .LOS_CYC(40), .INT_OFF_CYC(40)) uut (.*);
    mcs_host_model host (.clk_i(clk_i), .ack_i(mgmt_ack_o), .deselect_o(bus_deselect_i),
        .cmd_valid_o(mgmt_cmd_valid_i), .loop_sel_o(mgmt_loop_sel_i),
        .mode_o(mgmt_loop_mode_i), .flag_read_o(mgmt_flag_read_i));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Bounded wait; running out is a failure, not a hang
    task automatic wait_for(ref logic s, input logic v, input int lim);
        for (int i = 0; i < lim && s !== v; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk("wait", s, v);
        if (s !== v) tally_and_finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        srst_i <= 1'h0;
        step(1);
        chk("nr_init", module_not_ready_o, 8'h01);
        chk("absent", module_absent_o, 8'h00);
        @(posedge clk_i) status_i <= 4'hE;
        wait_for(module_not_ready_o, 1'h0, 20);
        for (int k = 0; k < 3; k++) begin
            host.send(1'h0, 1'h0, 2'((k + 2) % 3), acked);
            chk("ack", acked, 8'h01);
            step(1);
            chk("loop", {path_o.network_loopback, path_o.system_loopback}, 8'((k + 2) % 3));
        end
        // Last loop command left system mode, so a leaked write would show
        host.send(1'h1, 1'h0, 2'h2, acked);
        chk("ack_desel", acked, 8'h00);
        step(1);
        chk("loop_desel", {path_o.network_loopback, path_o.system_loopback}, 8'h01);
        chk("enable_desel", mgmt_enable_o, 8'h00);
        host.send(1'h0, 1'h0, 2'h0, acked);
        chk("ack_reselect", acked, 8'h01);
        chk("enable_sel", mgmt_enable_o, 8'h01);
        @(posedge clk_i) transmit_disable_i <= 1'h1;
        step(2);
        chk("laser_off", path_o.laser_enable, 8'h00);
        @(posedge clk_i) transmit_disable_i <= 1'h0;
        status_i.rx_signal_present <= 1'h0;
        wait_for(receive_signal_lost_o, 1'h1, 42);
        step(2);
        chk("nr_los", module_not_ready_o, 8'h01);
        // Lock was lost during the first cycles after reset, still sticky
        chk("flags_los", int_flags_o, 8'h03);
        chk("irq_los", interrupt_n_o, 8'h00);
        @(posedge clk_i) status_i.rx_signal_present <= 1'h1;
        step(2);
        host.send(1'h0, 1'h1, 2'h0, acked);
        step(1);
        chk("flags_clr", int_flags_o, 8'h00);
        wait_for(interrupt_n_o, 1'h1, 40);
        @(posedge clk_i) status_i.tx_pll_locked <= 1'h0;
        step(2);
        chk("alarm", tx_lock_alarm_o, 8'h01);
        chk("nr_lock", module_not_ready_o, 8'h01);
        @(posedge clk_i) power_down_i <= 1'h1;
        step(1000);
        chk("paths_off", path_o, 8'h00);
        @(posedge clk_i) power_down_i <= 1'h0;
        wait_for(internal_reset_o, 1'h1, 3);
        step(4);
        chk("nr_relock", module_not_ready_o, 8'h01);
        @(posedge clk_i) status_i.tx_pll_locked <= 1'h1;
        wait_for(module_not_ready_o, 1'h0, 20);
        chk("path_on", path_o.tx_path_enable, 8'h01);
        tally_and_finish;
    end
endmodule
bind mcs_ctrl mcs_ctrl_assertions chk_i (.*);
